/* rtl/sdl_pkg.sv */
/*
  Package for the serial DAC loader: frame layout and link timing constants.
  Assumes one system clock of 20 MHz on both ends of the link.
*/
// Summary of operation
// - Frame: four fill, ten code, two spare
// - Host sends two bytes, MSB first
// - Device samples data on rising clock, selected
// - Host moves select only while clock low
// - Sixteen-bit shift register, one step per rising edge
// - Select rising edge loads ten code bits
// - Deselected: nothing shifts, data ignored
// - Reset clears the DAC register to zero
// - Output lags input fifteen cycles plus half
// - Chain output changes on falling edges only
// - Chain output always driven, holds last bit
// - Host always sends the two spare bits
// - Straight binary code, output scales with code
// - Host idles clock low, data before rise
// - Host keeps clock low while deselected
// - Byte hosts send two bytes per select
// - Chains of any length via chain output
package sdl_pkg;
  localparam int FRAME_BITS = 16;
  localparam int FILL_BITS = 4;
  localparam int CODE_BITS = 10;
  localparam int SPARE_BITS = 2;
  localparam int BYTE_BITS = 8;
  localparam int CODE_LSB = SPARE_BITS;
  localparam int CODE_MSB = SPARE_BITS + CODE_BITS - 1;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int LINK_HALF_NS = 1000;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * (SYS_CLK_HZ / 1000000)) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
  localparam logic [FRAME_BITS-1:0] FRAME_RESET = 16'h0000;
  localparam logic [4:0] BITS_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(LINK_HALF_CYC - 1);
endpackage

/* rtl/sdl_link_if.sv */
/*
  Three-wire link plus daisy-chain return between host and DAC ends.
  Assumes the testbench joins both ends through this interface.
*/
`timescale 1ns/100ps
`default_nettype none
interface sdl_link_if;
  logic serial_clock;
  logic chip_select_n;
  logic serial_data_in;
  logic serial_data_out;
  modport host (output serial_clock, output chip_select_n,
    output serial_data_in, input serial_data_out);
  modport dac (input serial_clock, input chip_select_n,
    input serial_data_in, output serial_data_out);
endinterface
`default_nettype wire

/* rtl/sdl_dac.sv */
/*
  DAC end: samples the link with its own clock, shifts frames, loads code.
  Assumes link pins are asynchronous to sys_clk and far slower than it.
*/
`timescale 1ns/100ps
`default_nettype none
module sdl_dac
  import sdl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  sdl_link_if.dac link,
  output logic [sdl_pkg::CODE_BITS-1:0] dac_code,
  output logic code_loaded
);
  import sdl_pkg::*;

  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] csn_s;
    logic [1:0] din_s;
    logic sck_d;
    logic csn_d;
    logic [FRAME_BITS-1:0] shreg;
    logic dout;
    logic [CODE_BITS-1:0] code;
    logic loaded;
  } sdl_dac_s;

  sdl_dac_s st;
  sdl_dac_s next_st;
  logic sck_rise;
  logic sck_fall;
  logic csn_rise;

  // Only the second stage of each synchroniser feeds edge detection.
  assign sck_rise = st.sck_s[1] & ~st.sck_d;
  assign sck_fall = ~st.sck_s[1] & st.sck_d;
  assign csn_rise = st.csn_s[1] & ~st.csn_d;

  always_comb
  begin
    next_st = st;
    next_st.sck_s = {st.sck_s[0], link.serial_clock};
    next_st.csn_s = {st.csn_s[0], link.chip_select_n};
    next_st.din_s = {st.din_s[0], link.serial_data_in};
    next_st.sck_d = st.sck_s[1];
    next_st.csn_d = st.csn_s[1];
    next_st.loaded = 1'b0;
    // Deselected, the shift register and chain output hold.
    if (!st.csn_s[1] && sck_rise)
    begin
      next_st.shreg = {st.shreg[FRAME_BITS-2:0], st.din_s[1]};
    end
    if (!st.csn_s[1] && sck_fall)
    begin
      next_st.dout = st.shreg[FRAME_BITS-1];
    end
    if (csn_rise)
    begin
      // Straight binary, so no conversion is needed on the way out.
      next_st.code = st.shreg[CODE_MSB:CODE_LSB];
      next_st.loaded = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.sck_s <= 2'h0;
      st.csn_s <= 2'h3;
      st.csn_d <= 1'b1;
      st.shreg <= FRAME_RESET;
      st.code <= CODE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.serial_data_out = st.dout;
  assign dac_code = st.code;
  assign code_loaded = st.loaded;
endmodule // sdl_dac
`default_nettype wire

/* rtl/sdl_host.sv */
/*
  Host end: sends one 16-bit frame as two bytes in one select period.
  Assumes a single request pulse per frame, taken only while idle.
*/
`timescale 1ns/100ps
`default_nettype none
module sdl_host
  import sdl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  sdl_link_if.host link,
  input wire logic start,
  input wire logic [sdl_pkg::FRAME_BITS-1:0] frame,
  output logic busy,
  output logic [sdl_pkg::FRAME_BITS-1:0] echo
);
  import sdl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b011,
    ST_HOLD = 3'b100
  } sdl_host_state_e;

  typedef struct packed {
    sdl_host_state_e state;
    logic [CNT_W-1:0] half;
    logic [4:0] bits;
    logic [FRAME_BITS-1:0] tx;
    logic [FRAME_BITS-1:0] rx;
    logic [1:0] dout_s;
    logic sck;
    logic csn;
    logic mosi;
  } sdl_host_s;

  sdl_host_s st;
  sdl_host_s next_st;
  logic half_done;

  assign half_done = (st.half == HALF_LAST);

  always_comb
  begin
    next_st = st;
    next_st.dout_s = {st.dout_s[0], link.serial_data_out};
    next_st.half = half_done ? '0 : st.half + 1'b1;
    unique case (st.state)
      ST_IDLE:
      begin
        next_st.half = '0;
        next_st.sck = 1'b0;
        if (start)
        begin
          // Both bytes go out in one select, MSB first.
          next_st.tx = frame;
          next_st.bits = '0;
          next_st.csn = 1'b0;
          next_st.mosi = frame[FRAME_BITS-1];
          next_st.state = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (half_done)
        begin
          next_st.sck = 1'b1;
          next_st.state = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (half_done)
        begin
          next_st.sck = 1'b0;
          next_st.rx = {st.rx[FRAME_BITS-2:0], st.dout_s[1]};
          next_st.tx = {st.tx[FRAME_BITS-2:0], 1'b0};
          next_st.mosi = st.tx[FRAME_BITS-2];
          next_st.state = (st.bits == BITS_LAST) ? ST_HOLD : ST_LOW;
          next_st.bits = st.bits + 1'b1;
        end
      end
      ST_LOW:
      begin
        if (half_done)
        begin
          next_st.sck = 1'b1;
          next_st.state = ST_HIGH;
        end
      end
      ST_HOLD:
      begin
        if (half_done)
        begin
          // Clock is already low, so the select may rise now.
          next_st.csn = 1'b1;
          next_st.state = ST_IDLE;
        end
      end
      default:
      begin
        // Unused state codes fall back to idle rather than hang the link.
        next_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.state <= ST_IDLE;
      st.csn <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.serial_clock = st.sck;
  assign link.chip_select_n = st.csn;
  assign link.serial_data_in = st.mosi;
  assign busy = (st.state != ST_IDLE);
  assign echo = st.rx;
endmodule // sdl_host
`default_nettype wire

/* testbench/sdl_link_props.sv */
/* Checker on the link wires.
   Assumes sys_clk paces both ends. */
`timescale 1ns/100ps
`default_nettype none
module sdl_link_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out
);
  logic [4:0] rises;
  logic sck_q;
  // A delayed copy finds the clock edge, so the reset branch stays pure.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rises <= 5'h00;
      sck_q <= 1'b0;
    end
    else
    begin
      sck_q <= serial_clock;
      if (chip_select_n)
        rises <= 5'h00;
      else if (serial_clock && !sck_q)
        rises <= rises + 5'h01;
    end
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence sel_setup;
    !serial_clock [*8];
  endsequence
  chk_frame_len: assert property (
    $rose(chip_select_n) |-> rises == 5'h10) else $error("bit count");
  chk_csn_moves: assert property (
    $changed(chip_select_n) |-> !serial_clock) else $error("select move");
  chk_first_rise: assert property (
    $fell(chip_select_n) |-> sel_setup) else $error("select setup");
  chk_sck_idle: assert property (
    chip_select_n |-> !serial_clock) else $error("clock idle");
  chk_sdi_hold: assert property (
    serial_clock |-> $stable(serial_data_in)) else $error("data hold");
  chk_sck_half: assert property (
    $changed(serial_clock) |=> $stable(serial_clock) [*8])
    else $error("half period");
  chk_sdo_edge: assert property (
    $changed(serial_data_out) |-> !serial_clock && !chip_select_n)
    else $error("chain edge");
  chk_sdo_hold: assert property (
    chip_select_n && $past(chip_select_n) |-> $stable(serial_data_out))
    else $error("chain hold");
  chk_frame_time: assert property (
    $fell(chip_select_n) |-> ##[600:720] $rose(chip_select_n))
    else $error("frame time");
endmodule // sdl_link_props
`default_nettype wire

/* testbench/tb.sv */
/* Bench: host end and DAC end joined by the link.
   Assumes the host paces the link from sys_clk. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [15:0] frame = 16'h0000;
  logic [15:0] prev = 16'h0000;
  logic busy;
  logic code_loaded;
  logic [15:0] echo;
  logic [9:0] dac_code;
  int bad_count = 0;
  int num_checks = 0;
  logic [25:0] rows [4] = '{{16'hf003, 10'h000}, {16'h0ffc, 10'h3ff},
    {16'h0800, 10'h200}, {16'h07fc, 10'h1ff}};
  sdl_link_if link ();
  sdl_host i_sdl_host (.sys_clk(sys_clk), .nrst(nrst), .link(link),
    .start(start), .frame(frame), .busy(busy), .echo(echo));
  sdl_dac i_sdl_dac (.sys_clk(sys_clk), .nrst(nrst), .link(link),
    .dac_code(dac_code), .code_loaded(code_loaded));
  sdl_link_props i_sdl_link_props (.sys_clk(sys_clk), .nrst(nrst),
    .serial_clock(link.serial_clock), .chip_select_n(link.chip_select_n),
    .serial_data_in(link.serial_data_in),
    .serial_data_out(link.serial_data_out));
  always #25 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pulse(input logic [15:0] f);
    @(posedge sys_clk) #1 frame = f;
    start = 1'b1;
    @(posedge sys_clk) #1 start = 1'b0;
  endtask
  task automatic send(input logic [15:0] f, input logic [9:0] code,
    input logic poke);
    int n;
    pulse(f);
    // A second start in mid-frame must be dropped, not queued.
    if (poke)
    begin
      repeat (100) @(posedge sys_clk);
      pulse(~f);
    end
    for (n = 0; n < 2000 && code_loaded !== 1'b1; n++)
      @(posedge sys_clk) #1;
    check({15'h0, code_loaded}, 16'h0001);
    check({6'h00, dac_code}, {6'h00, code});
    check({15'h0, busy}, 16'h0000);
    check(echo, prev);
    prev = f;
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1 nrst = 1'b1;
    check({6'h00, dac_code}, 16'h0000);
    check(echo, 16'h0000);
    foreach (rows[i])
      send(rows[i][25:10], rows[i][9:0], 1'b0);
    send(16'h5556, 10'h155, 1'b1);
    pulse(16'h0ffc);
    repeat (300) @(posedge sys_clk);
    #1 nrst = 1'b0;
    @(posedge sys_clk) #1 nrst = 1'b1;
    check({6'h00, dac_code}, 16'h0000);
    prev = 16'h0000;
    send(16'h0004, 10'h001, 1'b0);
    report_and_stop();
  end
  initial
  begin
    #1000000;
    bad_count++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
